// file: lcdcd_decode.sv
// Contrast instruction checker and level decoder.
// Purely combinational; the parent registers each result it connects.
`timescale 1ns/10ps
`default_nettype none
module lcdcd_decode
	import lcdcd_pkg::*;
(
	input  wire logic [15:0] instr,      // Received instruction D256..D271
	input  wire logic [5:0]  code,       // Latched contrast code
	output logic             is_contrast, // Instruction is a contrast one
	output logic [10:0]      level       // Top bias level, 10 mV units
);
	// Fixed bits must match exactly, else the word is some other command
	always_comb
	begin
		is_contrast = (instr[15:LCDCD_TAG_LSB] == LCDCD_TAG);
	end
	// Unsigned step times fixed step below top
	always_comb
	begin
		// Both factors widened first: step 63 needs ten bits of product
		level = LCDCD_TOP_MV10 - (11'(code) * 11'(LCDCD_STEP_MV10));
	end
endmodule
`default_nettype wire

// file: lcdcd_duty.sv
// Duty field decoder: maps the 4-bit field to a denominator 8..16.
// Codes outside the range clamp, so the drive never sees an illegal duty.
`timescale 1ns/10ps
`default_nettype none
module lcdcd_duty
	import lcdcd_pkg::*;
(
	input  wire logic [3:0] duty_field, // Duty code
	output logic [4:0]      duty_n      // Duty denominator
);
	// Code k gives 1/(8+k), clamped at 1/16
	always_comb
	begin
		if ({1'b0, duty_field} > (LCDCD_DUTY_MAX - LCDCD_DUTY_MIN))
			duty_n = LCDCD_DUTY_MAX;
		else
			duty_n = LCDCD_DUTY_MIN + {1'b0, duty_field};
	end
endmodule
`default_nettype wire

// file: lcdcd_host_model.sv
// Host model: one register transfer at a time.
// Waits at most fifty edges for an answer, else raises tmo.
`timescale 1ns/10ps
`default_nettype none
module lcdcd_host_model
	import lcdcd_pkg::*;
(
	input  wire logic        aclk,       // Clock
	output logic             s_awvalid,  // AW valid
	input  wire logic        s_awready,  // AW ready
	output logic [7:0]       s_awaddr,   // AW address
	output logic             s_wvalid,   // W valid
	input  wire logic        s_wready,   // W ready
	output logic [31:0]      s_wdata,    // W data
	output logic [3:0]       s_wstrb,    // W strobes
	input  wire logic        s_bvalid,   // B valid
	output logic             s_bready,   // B ready
	input  wire logic [1:0]  s_bresp,    // B code
	output logic             s_arvalid,  // AR valid
	input  wire logic        s_arready,  // AR ready
	output logic [7:0]       s_araddr,   // AR address
	input  wire logic        s_rvalid,   // R valid
	output logic             s_rready,   // R ready
	input  wire logic [31:0] s_rdata,    // R data
	input  wire logic [1:0]  s_rresp,    // R code
	output logic             tmo         // No answer came
);
	// Idle bus from time zero
	initial {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, tmo} = 6'h00;
	initial {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
	// Each valid drops when taken, each ready when answered
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q, output logic [1:0] r);
		int n;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} <= {a, a, d, s};
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {wr, wr, wr, !wr, !wr};
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (!(s_awvalid || s_wvalid || s_bready || s_arvalid || s_rready))
				break;
			if (s_awready)
				s_awvalid <= 1'b0;
			if (s_wready)
				s_wvalid <= 1'b0;
			if (s_arready)
				s_arvalid <= 1'b0;
			if (s_bvalid)
			begin
				r = s_bresp;
				s_bready <= 1'b0;
			end
			if (s_rvalid)
			begin
				{q, r} = {s_rdata, s_rresp};
				s_rready <= 1'b0;
			end
		end
		if (n == 50)
			tmo <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: lcdcd_pkg.sv
// Package for the display contrast and drive mode block.
// Holds register map, field layouts, reset values and carrier structs.
// Assumes an AXI4-Lite master with 32-bit data on the register side.
// How it works
// - 16-bit instruction, tag 0110100000 in bits 15:6
// - Six-bit code from low bits, LSB first
// - Code is step; 14.10 V minus 0.15 V each
// - Code drives level only with adjuster enabled
// - Bias select 0 quarter, 1 fifth
// - Inversion select 0 line, 1 frame
// - Duty 1/8 to 1/16 in every mode
// - Duty and frame rate from 4-bit fields
`default_nettype none
package lcdcd_pkg;
	// Register byte offsets
	localparam logic [7:0] LCDCD_OFF_INSTR   = 8'h00; // Contrast instruction word
	localparam logic [7:0] LCDCD_OFF_METHOD  = 8'h04; // Display method fields
	localparam logic [7:0] LCDCD_OFF_STATUS  = 8'h08; // Drive state readback
	// Contrast instruction layout
	localparam int        LCDCD_CODE_W       = 6;     // Contrast code width
	localparam int        LCDCD_TAG_LSB      = 6;     // Start of fixed part
	localparam logic [9:0] LCDCD_TAG         = 10'h1a0; // Word bits 15:6, D271 down to D262
	// Method register field positions
	localparam int        LCDCD_DUTY_LSB     = 0;     // Duty field, 4 bits
	localparam int        LCDCD_FRATE_LSB    = 4;     // Frame rate field, 4 bits
	localparam int        LCDCD_BIAS_BIT     = 8;     // Bias ratio select
	localparam int        LCDCD_INV_BIT      = 9;     // Inversion select
	localparam int        LCDCD_COMDIR_BIT   = 10;    // Common direction select
	localparam int        LCDCD_CLK_BIT      = 11;    // Clock source select
	localparam int        LCDCD_ADJ_BIT      = 12;    // Contrast adjuster enable
	// Reset values
	localparam logic [5:0]  LCDCD_CODE_RST   = 6'h00; // Step 0
	localparam logic [12:0] LCDCD_METHOD_RST = 13'h0000;
	// Level arithmetic in units of 10 mV
	localparam logic [10:0] LCDCD_TOP_MV10   = 11'h582; // 14.10 V
	localparam logic [4:0]  LCDCD_STEP_MV10  = 5'h0f;   // 0.15 V
	// Duty range
	localparam logic [4:0]  LCDCD_DUTY_MIN   = 5'h08;
	localparam logic [4:0]  LCDCD_DUTY_MAX   = 5'h10;
	// Drive mode carrier
	typedef struct packed {
		logic       adj_en;                    // Contrast adjuster in use
		logic       clock_source_select;       // 1 external clock
		logic       common_direction_select;   // Common scan direction
		logic       inversion_select;          // 0 line, 1 frame
		logic       bias_ratio_select;         // 0 quarter, 1 fifth
		logic [3:0] frame_rate_field;          // Frame frequency code
		logic [3:0] duty_field;                // Duty code
	} lcdcd_method_t;
	// Decoded drive carrier
	typedef struct packed {
		logic        level_valid;              // Level below is in force
		logic [10:0] top_bias_level;           // Top bias level, 10 mV units
		logic [4:0]  duty_n;                   // Duty denominator 8..16
	} lcdcd_drive_t;
endpackage
`default_nettype wire

// file: lcdcd_properties.sv
// Checker for the contrast and drive mode block, bound to its top.
// Sees top ports only; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module lcdcd_checker
	import lcdcd_pkg::*;
(
	input wire logic          aclk,          // Clock
	input wire logic          aresetn,       // Reset, low
	input wire logic          ce,            // Clock enable
	input wire logic          s_awvalid,     // Address offered
	input wire logic          s_wvalid,      // Data offered
	input wire logic          s_bvalid,      // Response valid
	input wire logic [1:0]    s_bresp,       // Response code
	input wire lcdcd_method_t mode_out,      // Mode fields
	input wire lcdcd_drive_t  drive_out,     // Level and duty
	input wire logic [5:0]    contrast_code  // Latched code
);
	// A low enable freezes state, so checks pause with it
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	// Write answered OKAY
	sequence s_ok;
		s_bvalid && s_bresp == 2'b00;
	endsequence
	// Bus quiet for three edges
	sequence s_idle;
		(!s_awvalid && !s_wvalid) [*3];
	endsequence
	property p_code_wr;
		$changed(contrast_code) && $past(aresetn) |-> ##[0:2] s_ok;
	endproperty
	a_code_wr: assert property (p_code_wr) else $error("code moved without write");
	property p_code_hold;
		s_idle |=> $stable(contrast_code);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code moved idle");
	property p_level;
		$past(mode_out.adj_en) |-> drive_out.level_valid
			&& drive_out.top_bias_level == 1410 - 15 * $past(contrast_code);
	endproperty
	a_level: assert property (p_level) else $error("wrong level");
	property p_adj_off;
		!$past(mode_out.adj_en) |-> !drive_out.level_valid && drive_out.top_bias_level == 0;
	endproperty
	a_adj_off: assert property (p_adj_off) else $error("level while off");
	property p_duty;
		$past(aresetn) |-> drive_out.duty_n == ($past(mode_out.duty_field) > 8 ? 16
			: 8 + $past(mode_out.duty_field));
	endproperty
	a_duty: assert property (p_duty) else $error("wrong duty");
	property p_duty_rng;
		$past(aresetn) |-> drive_out.duty_n inside {[8:16]};
	endproperty
	a_duty_rng: assert property (p_duty_rng) else $error("duty range");
	property p_bias;
		$changed(mode_out.bias_ratio_select) && $past(aresetn) |-> ##[0:2] s_ok;
	endproperty
	a_bias: assert property (p_bias) else $error("bias moved");
	property p_inv;
		$changed(mode_out.inversion_select) && $past(aresetn) |-> ##[0:2] s_ok;
	endproperty
	a_inv: assert property (p_inv) else $error("inversion moved");
endmodule
bind lcdcd_top lcdcd_checker u_props (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.ce            (ce),
	.s_awvalid     (s_awvalid),
	.s_wvalid      (s_wvalid),
	.s_bvalid      (s_bvalid),
	.s_bresp       (s_bresp),
	.mode_out      (mode_out),
	.drive_out     (drive_out),
	.contrast_code (contrast_code)
);
`default_nettype wire

// file: lcdcd_top.sv
// Top of the display contrast and drive mode block.
// AXI4-Lite slave carries contrast instructions and method fields;
// outputs feed the analog bias generator and the common/segment drivers.
`timescale 1ns/10ps
`default_nettype none
module lcdcd_top
	import lcdcd_pkg::*;
(
	input  wire logic        aclk,          // Clock, 50 MHz
	input  wire logic        aresetn,       // Synchronous reset, low
	input  wire logic        ce,            // Clock enable
	input  wire logic        s_awvalid,     // Write address valid
	output logic             s_awready,     // Write address ready
	input  wire logic [7:0]  s_awaddr,      // Write address
	input  wire logic        s_wvalid,      // Write data valid
	output logic             s_wready,      // Write data ready
	input  wire logic [31:0] s_wdata,       // Write data
	input  wire logic [3:0]  s_wstrb,       // Byte strobes
	output logic             s_bvalid,      // Write response valid
	input  wire logic        s_bready,      // Write response ready
	output logic [1:0]       s_bresp,       // Write response
	input  wire logic        s_arvalid,     // Read address valid
	output logic             s_arready,     // Read address ready
	input  wire logic [7:0]  s_araddr,      // Read address
	output logic             s_rvalid,      // Read data valid
	input  wire logic        s_rready,      // Read data ready
	output logic [31:0]      s_rdata,       // Read data
	output logic [1:0]       s_rresp,       // Read response
	output lcdcd_method_t    mode_out,      // Drive mode selections
	output lcdcd_drive_t     drive_out,     // Level and duty to drivers
	output logic [5:0]       contrast_code  // Latched contrast code
);
	// Write channel state
	logic        aw_held_r, aw_held_nxt;   // Address captured
	logic        w_held_r,  w_held_nxt;    // Data captured
	logic        awready_r, awready_nxt;   // Address ready, registered
	logic        wready_r,  wready_nxt;    // Data ready, registered
	logic [7:0]  waddr_r,   waddr_nxt;     // Captured address
	logic [31:0] wdata_r,   wdata_nxt;     // Captured data
	logic [3:0]  wstrb_r,   wstrb_nxt;     // Captured strobes
	logic        bvalid_r,  bvalid_nxt;    // Response pending
	logic [1:0]  bresp_r,   bresp_nxt;     // Response code
	// Read channel state
	logic        rvalid_r,  rvalid_nxt;    // Read data pending
	logic        arready_r, arready_nxt;   // Read address ready, registered
	logic [31:0] rdata_r,   rdata_nxt;     // Read data
	logic [1:0]  rresp_r,   rresp_nxt;     // Read response
	// Block state
	logic [5:0]    code_r,   code_nxt;     // Contrast code
	lcdcd_method_t meth_r,   meth_nxt;     // Method fields
	lcdcd_drive_t  drive_r,  drive_nxt;    // Registered drive outputs
	logic [15:0]   last_r,   last_nxt;     // Last instruction word seen
	logic          rej_r,    rej_nxt;      // Last instruction refused
	// Decoder results
	logic        dec_is_contrast;          // Incoming word is contrast
	logic [10:0] level_now;                // Level of latched code
	logic [4:0]  duty_now;                 // Duty from latched field
	logic        do_write;                 // Both halves held
	logic [15:0] wr_instr;                 // Instruction half of write

	// Layout guard: code and fixed part must fill the 16-bit word exactly
	if (LCDCD_CODE_W != LCDCD_TAG_LSB || LCDCD_TAG_LSB + $bits(LCDCD_TAG) != 16)
	begin : g_layout_bad
		$error("contrast code and fixed part do not fill the instruction word");
	end
	// Duty range must fit the 4-bit duty field
	if (LCDCD_DUTY_MAX - LCDCD_DUTY_MIN > 5'h0f)
	begin : g_duty_bad
		$error("duty range wider than the duty field");
	end

	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wr_instr = wdata_r[15:0];

	// Check the pending write for the contrast pattern
	lcdcd_decode u_chk (
		.instr       (wr_instr),
		.code        (code_r),
		.is_contrast (dec_is_contrast),
		.level       ()
	);
	// Level from the code already latched
	lcdcd_decode u_lvl (
		.instr       (last_r),
		.code        (code_r),
		.is_contrast (),
		.level       (level_now)
	);
	// Duty denominator
	lcdcd_duty u_duty (
		.duty_field (meth_r.duty_field),
		.duty_n     (duty_now)
	);

	// Write path: take address and data in either order, answer after both
	always_comb
	begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		waddr_nxt   = waddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		code_nxt    = code_r;
		meth_nxt    = meth_r;
		last_nxt    = last_r;
		rej_nxt     = rej_r;
		if (s_awvalid && !aw_held_r)
		begin
			aw_held_nxt = 1'b1;
			waddr_nxt   = s_awaddr;
		end
		if (s_wvalid && !w_held_r)
		begin
			w_held_nxt = 1'b1;
			wdata_nxt  = s_wdata;
			wstrb_nxt  = s_wstrb;
		end
		if (do_write)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = 2'b00;
			case (waddr_r)
				LCDCD_OFF_INSTR:
				begin
					// Whole word only: a partial write cannot form an instruction
					if (wstrb_r[1:0] == 2'b11)
					begin
						last_nxt = wr_instr;
						rej_nxt  = !dec_is_contrast;
						if (dec_is_contrast)
							code_nxt = wr_instr[LCDCD_CODE_W-1:0];
					end
					else
						rej_nxt = 1'b1;
				end
				LCDCD_OFF_METHOD:
				begin
					if (wstrb_r[0])
						meth_nxt[7:0] = wdata_r[7:0];
					if (wstrb_r[1])
						meth_nxt[12:8] = wdata_r[LCDCD_ADJ_BIT:LCDCD_BIAS_BIT];
				end
				LCDCD_OFF_STATUS:
					bresp_nxt = 2'b10; // Read-only
				default:
					bresp_nxt = 2'b11; // Unmapped
			endcase
		end
		if (bvalid_r && s_bready)
			bvalid_nxt = 1'b0;
		// Readies mirror an empty holder one cycle ahead, so they leave flops
		awready_nxt = !aw_held_nxt;
		wready_nxt  = !w_held_nxt;
	end

	// Read path: one outstanding read, answered the cycle after address
	always_comb
	begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (s_arvalid && !rvalid_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'b00;
			case (s_araddr)
				// Last whole-word instruction, accepted or not
				LCDCD_OFF_INSTR:
					rdata_nxt = {16'h0000, last_r};
				// Mode fields as stored
				LCDCD_OFF_METHOD:
					rdata_nxt = {19'h00000, meth_r};
				// Refusal flag, level valid, code, duty, level
				LCDCD_OFF_STATUS:
					rdata_nxt = {8'h00, rej_r, drive_r.level_valid, code_r,
						drive_r.duty_n, drive_r.top_bias_level};
				// Unmapped: zero data with a decode error
				default:
				begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = 2'b11;
				end
			endcase
		end
		else if (rvalid_r && s_rready)
			rvalid_nxt = 1'b0;
		// Ready leaves a flop: low while an answer waits for rready
		arready_nxt = !rvalid_nxt;
	end

	// Drive outputs follow the latched settings one cycle later
	always_comb
	begin
		drive_nxt.level_valid = meth_r.adj_en;
		// Without the adjuster the level is external; hold zero there
		drive_nxt.top_bias_level = meth_r.adj_en ? level_now : 11'h000;
		drive_nxt.duty_n = duty_now;
	end

	// Write channel registers; ce low freezes them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// Readies come up high so the first request is taken at once
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
			w_held_r  <= 1'b0;
			wready_r  <= 1'b1;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'b00;
		end
		else if (ce)
		begin
			aw_held_r <= aw_held_nxt;
			awready_r <= awready_nxt;
			w_held_r  <= w_held_nxt;
			wready_r  <= wready_nxt;
			waddr_r   <= waddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	// Read channel registers; ce low freezes them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= 2'b00;
		end
		else if (ce)
		begin
			rvalid_r  <= rvalid_nxt;
			arready_r <= arready_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// Settings registers: code, mode fields, last word, refusal flag
	// Held through ce low, so a paused clock never loses a setting
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			code_r    <= LCDCD_CODE_RST;
			meth_r    <= LCDCD_METHOD_RST;
			last_r    <= 16'h0000;
			rej_r     <= 1'b0;
		end
		else if (ce)
		begin
			code_r    <= code_nxt;
			meth_r    <= meth_nxt;
			last_r    <= last_nxt;
			rej_r     <= rej_nxt;
		end
	end

	// Drive registers: one cycle behind the settings
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			drive_r   <= '0;
		end
		else if (ce)
		begin
			drive_r   <= drive_nxt;
		end
	end

	// Every port below leaves a flop directly; readies are kept as flops
	// of their own so no inverter sits between state and pin
	assign s_awready     = awready_r;
	assign s_wready      = wready_r;
	assign s_bvalid      = bvalid_r;
	assign s_bresp       = bresp_r;
	assign s_arready     = arready_r;
	assign s_rvalid      = rvalid_r;
	assign s_rdata       = rdata_r;
	assign s_rresp       = rresp_r;
	assign mode_out      = meth_r;
	assign drive_out     = drive_r;
	assign contrast_code = code_r;
endmodule
`default_nettype wire

// file: tb_lcd_contrast_and_drive_mode.sv
// Testbench: host model drives the bus; outputs compared here.
// Ties clock enable high; the checker is bound to the top.
`timescale 1ns/10ps
`default_nettype none
module tb_lcd_contrast_and_drive_mode;
	import lcdcd_pkg::*;
	logic          aclk, aresetn, ce, tmo;
	logic          s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic          s_arvalid, s_arready, s_rvalid, s_rready;
	logic [7:0]    s_awaddr, s_araddr;
	logic [31:0]   s_wdata, s_rdata, q;
	logic [3:0]    s_wstrb;
	logic [1:0]    s_bresp, s_rresp, r;
	lcdcd_method_t mode_out, m;
	lcdcd_drive_t  drive_out;
	logic [5:0]    contrast_code;
	logic [5:0]    codes [4] = '{6'h00, 6'h01, 6'h20, 6'h3f}; // Steps 0 to 63
	int            err_total, checks_done, i;
	lcdcd_top DUT (.*);
	lcdcd_host_model u_host (.*);
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		u_host.xfer(1'b1, a, d, s, q, r);
		chk("bresp", 32'(r), 32'(er));
		repeat (2) @(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		u_host.xfer(1'b0, a, 32'h0, 4'h0, q, r);
		chk("rresp", 32'(r), 32'(er));
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// A hung transfer ends the run
	always @(posedge aclk)
		if (tmo)
		begin
			err_total++;
			stop_test;
		end
	initial
	begin
		aresetn = 1'b0;
		ce = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (50000) @(posedge aclk);
		chk("code", 32'(contrast_code), 32'h0);
		chk("valid", 32'(drive_out.level_valid), 32'h0);
		// Every select pattern and duty code, adjuster on
		for (i = 0; i < 16; i++)
		begin
			m = {1'b1, 4'(i), ~4'(i), 4'(i)};
			wr(8'h04, 32'(m), 4'hf, 2'b00);
			chk("mode", 32'(mode_out), 32'(m));
			chk("duty", 32'(drive_out.duty_n), i > 8 ? 16 : 8 + i);
		end
		// Supply taken as high enough for step 0
		foreach (codes[k])
		begin
			wr(8'h00, {16'h0, 10'h1a0, codes[k]}, 4'h3, 2'b00);
			chk("code", 32'(contrast_code), 32'(codes[k]));
			chk("level", 32'(drive_out.top_bias_level), 1410 - 15 * codes[k]);
			chk("valid", 32'(drive_out.level_valid), 32'h1);
		end
		// Wrong tag, stray one bit, half word: all refused
		wr(8'h00, 32'h0000_6015, 4'hf, 2'b00);
		wr(8'h00, 32'h0000_6855, 4'hf, 2'b00);
		wr(8'h00, 32'h0000_6815, 4'h1, 2'b00);
		rd(8'h08, 2'b00);
		chk("status", 32'(q[21:16]), 32'h3f);
		chk("refused", 32'(q[23]), 32'h1);
		wr(8'h04, 32'h0, 4'hf, 2'b00);
		chk("off", 32'({drive_out.level_valid, drive_out.top_bias_level}), 32'h0);
		wr(8'h08, 32'h0, 4'hf, 2'b10);
		wr(8'h3c, 32'h0, 4'hf, 2'b11);
		chk("kept", 32'(contrast_code), 32'h3f);
		rd(8'h3c, 2'b11);
		chk("unmapped", q, 32'h0);
		rd(8'h04, 2'b00);
		chk("method", q, 32'h0);
		// Last whole-word instruction stays readable though it was refused
		rd(8'h00, 2'b00);
		chk("last", q, 32'h0000_6855);
		stop_test;
	end
endmodule
`default_nettype wire
